/* inc/lsf_cfg.svh */
// Offsets, field positions, codes and reset values of the link-on and self-ID framer
`ifndef LSF_CFG_SVH
`define LSF_CFG_SVH
`define LSF_LOC_LEAD   8'h80
`define LSF_LOC_TAIL   8'h8c
`define LSF_MARK       16'h00e0
`define LSF_MARK_LSB   4
`define LSF_NIB_CLR    4'h0
`define LSF_TCODE_SID  4'he
`define LSF_TCODE_LSB  4
`define LSF_PRI_LSB    0
`define LSF_SPD_LSB    16
`define LSF_ACK_LSB    0
`define LSF_SPD_100    2'h0
`define LSF_SPD_200    2'h1
`define LSF_SPD_400    2'h2
`define LSF_RST_WORD   32'h0000_0000
`endif

/* inc/lsf_pkg.sv */
// Types shared by the link-on and self-ID framer
package lsf_pkg;
  typedef struct packed {
    logic [7:0]  loc;
    logic [31:0] data;
  } lsf_tx_in_t;
  typedef struct packed {
    logic        link_on;
    logic        last;
    logic [31:0] data;
  } lsf_phy_word_t;
  typedef struct packed {
    logic        hdr;
    logic        stat;
    logic [31:0] data;
  } lsf_rx_word_t;
  typedef enum logic [1:0] {
    LSF_RX_IDLE = 2'b00,
    LSF_RX_HEAD = 2'b01,
    LSF_RX_DATA = 2'b10,
    LSF_RX_STAT = 2'b11
  } lsf_rx_st_t;
endpackage : lsf_pkg

/* src/lsf_framer.sv */
// Link-on transmit formatter and self-ID receive record builder with output buffers
//
// Contract
// R01: Host builds a link-on request as exactly two quadlets in the transmit FIFO.
// R02: Host writes the leading link-on quadlet to FIFO location 80h.
// R03: Host writes the trailing quadlet to location 8Ch, ending the packet.
// R04: Leading quadlet with low half 00E0h marks a link-on request.
// R05: Marker nibble Eh is replaced with 0h before the physical interface.
// R06: Top two bits of the leading quadlet hold identifier 01.
// R07: Field after the identifier holds the target node number.
// R08: Trailing upper half inverts leading upper half; lower half all ones.
// R09: Self-ID record starts with a header quadlet whose transaction code is Eh.
// R10: Self-ID quadlets follow the header back to back.
// R11: One status quadlet ends the self-ID record.
// R12: Header carries the priority field of the received packet.
// R13: Speed code 00, 01, 10 for 100, 200, 400 Mbit/s.
// R14: Status quadlet holds the returned acknowledge code.
`timescale 1ns/1ps
`include "lsf_cfg.svh"

// Two-entry buffer so a stalled receiver loses no word
module lsf_buf2 #(
  parameter int W = 34
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  // Handshakes from the fill count
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage per entry; each entry register has a single writer process
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ent
      logic [W-1:0] ent_r;
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          ent_r <= '0;
        end else if (push && (wp_r == 1'(gi))) begin
          ent_r <= in_data;
        end
      end
    end
  endgenerate

  // Read side selects the oldest entry
  assign out_data = rp_r ? g_ent[1].ent_r : g_ent[0].ent_r;

  // Pointers and count
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r  <= wp_r ^ push;
      rp_r  <= rp_r ^ pop;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : lsf_buf2

module lsf_framer (
  input  wire logic                   clock,
  input  wire logic                   reset,
  // Quadlets drained from the async_transmit_fifo
  input  wire logic                   tx_valid,
  output logic                        tx_ready,
  input  wire lsf_pkg::lsf_tx_in_t    tx_in,
  // Toward the physical-layer interface
  output logic                        phy_valid,
  input  wire logic                   phy_ready,
  output lsf_pkg::lsf_phy_word_t      phy_word,
  // Self-ID quadlets from the receiver
  input  wire logic                   sid_valid,
  output logic                        sid_ready,
  input  wire logic [31:0]            sid_data,
  input  wire logic                   sid_last,
  input  wire logic [3:0]             rx_priority,
  input  wire logic [1:0]             rx_speed,
  input  wire logic [3:0]             returned_ack_code,
  // Toward the receive FIFO
  output logic                        rxf_valid,
  input  wire logic                   rxf_ready,
  output lsf_pkg::lsf_rx_word_t       rxf_word
);
  localparam int PW = $bits(lsf_pkg::lsf_phy_word_t);
  localparam int RW = $bits(lsf_pkg::lsf_rx_word_t);

  // ---- Transmit side ----
  logic                   tx_start_r;
  logic                   tx_lo_r;
  logic                   tx_push_rdy;
  logic                   tx_fire;
  logic                   tx_is_lead;
  logic                   tx_is_tail;
  logic                   tx_mark_hit;
  logic                   tx_lo_now;
  logic [31:0]            tx_fixed;
  lsf_pkg::lsf_phy_word_t tx_push_word;

  // Leading quadlet decode; host keeps the two-quadlet layout
  assign tx_fire     = tx_valid && tx_push_rdy;
  assign tx_is_lead  = (tx_in.loc == `LSF_LOC_LEAD); // see R02
  assign tx_is_tail  = (tx_in.loc == `LSF_LOC_TAIL); // see R03
  assign tx_mark_hit = tx_start_r && tx_is_lead && (tx_in.data[15:0] == `LSF_MARK); // see R04
  assign tx_lo_now   = tx_mark_hit || (!tx_start_r && tx_lo_r);

  // Marker nibble is cleared only on the leading quadlet of a link-on
  always_comb begin
    tx_fixed = tx_in.data;
    if (tx_mark_hit) begin
      tx_fixed[`LSF_MARK_LSB +: 4] = `LSF_NIB_CLR; // see R05
    end
  end

  assign tx_push_word.link_on = tx_lo_now;
  assign tx_push_word.last    = tx_is_tail;
  assign tx_push_word.data    = tx_fixed;
  assign tx_ready             = tx_push_rdy;

  // Packet boundary tracking; a tail quadlet reopens the start window
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_start_r <= 1'b1;
      tx_lo_r    <= 1'b0;
    end else if (tx_fire) begin
      tx_start_r <= tx_is_tail; // see R01
      tx_lo_r    <= tx_lo_now && !tx_is_tail;
    end
  end

  lsf_buf2 #(.W(PW)) u_tx_buf (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (tx_valid),
    .in_ready  (tx_push_rdy),
    .in_data   (tx_push_word),
    .out_valid (phy_valid),
    .out_ready (phy_ready),
    .out_data  (phy_word)
  );

  // ---- Receive side ----
  lsf_pkg::lsf_rx_st_t   rx_st_r;
  lsf_pkg::lsf_rx_st_t   rx_st_nxt;
  logic [3:0]            pri_r;
  logic [1:0]            spd_r;
  logic [3:0]            ack_r;
  logic                  rx_push;
  logic                  rx_push_rdy;
  logic                  sid_fire;
  logic [31:0]           hdr_q;
  logic [31:0]           stat_q;
  lsf_pkg::lsf_rx_word_t rx_push_word;

  // Header and status quadlets assembled from latched fields
  always_comb begin
    hdr_q  = `LSF_RST_WORD;
    stat_q = `LSF_RST_WORD;
    hdr_q[`LSF_TCODE_LSB +: 4] = `LSF_TCODE_SID; // see R09
    hdr_q[`LSF_PRI_LSB +: 4]   = pri_r; // see R12
    stat_q[`LSF_SPD_LSB +: 2]  = spd_r; // see R13
    stat_q[`LSF_ACK_LSB +: 4]  = ack_r; // see R14
  end

  // Self-ID words pass only while the body is open, so the header goes first
  assign sid_ready = (rx_st_r == lsf_pkg::LSF_RX_DATA) && rx_push_rdy; // see R10
  assign sid_fire  = sid_valid && sid_ready;
  assign rx_push   = sid_fire
                   || (rx_st_r == lsf_pkg::LSF_RX_HEAD)
                   || (rx_st_r == lsf_pkg::LSF_RX_STAT);
  assign rx_push_word.hdr  = (rx_st_r == lsf_pkg::LSF_RX_HEAD);
  assign rx_push_word.stat = (rx_st_r == lsf_pkg::LSF_RX_STAT);
  assign rx_push_word.data = (rx_st_r == lsf_pkg::LSF_RX_HEAD) ? hdr_q
                           : (rx_st_r == lsf_pkg::LSF_RX_STAT) ? stat_q
                           : sid_data;

  // Record sequencer: header, body, status
  always_comb begin
    rx_st_nxt = rx_st_r;
    case (rx_st_r)
      lsf_pkg::LSF_RX_IDLE: begin
        if (sid_valid) begin
          rx_st_nxt = lsf_pkg::LSF_RX_HEAD;
        end
      end
      lsf_pkg::LSF_RX_HEAD: begin
        if (rx_push_rdy) begin
          rx_st_nxt = lsf_pkg::LSF_RX_DATA;
        end
      end
      lsf_pkg::LSF_RX_DATA: begin
        if (sid_fire && sid_last) begin
          rx_st_nxt = lsf_pkg::LSF_RX_STAT; // see R11
        end
      end
      lsf_pkg::LSF_RX_STAT: begin
        if (rx_push_rdy) begin
          rx_st_nxt = lsf_pkg::LSF_RX_IDLE;
        end
      end
      default: begin
        rx_st_nxt = lsf_pkg::LSF_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_st_r <= lsf_pkg::LSF_RX_IDLE;
    end else begin
      rx_st_r <= rx_st_nxt;
    end
  end

  // Priority caught at record start; speed and ack at the last self-ID word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pri_r <= 4'h0;
      spd_r <= `LSF_SPD_100;
      ack_r <= 4'h0;
    end else begin
      if ((rx_st_r == lsf_pkg::LSF_RX_IDLE) && sid_valid) begin
        pri_r <= rx_priority;
      end
      if (sid_fire && sid_last) begin
        spd_r <= rx_speed;
        ack_r <= returned_ack_code;
      end
    end
  end

  lsf_buf2 #(.W(RW)) u_rx_buf (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (rx_push),
    .in_ready  (rx_push_rdy),
    .in_data   (rx_push_word),
    .out_valid (rxf_valid),
    .out_ready (rxf_ready),
    .out_data  (rxf_word)
  );

  // ---- Checks ----
  property p_mark_detect;
    @(posedge clock) disable iff (reset)
    tx_fire && tx_start_r && tx_is_lead && (tx_in.data[15:0] == `LSF_MARK)
      |=> phy_valid && (tx_lo_r || tx_start_r);
  endproperty
  a_mark_detect: assert property (p_mark_detect) // see R04
    else $error("link-on marker not recognised");

  property p_nib_clear;
    @(posedge clock) disable iff (reset)
    tx_fire && tx_mark_hit |-> tx_push_word.link_on
      && (tx_push_word.data[`LSF_MARK_LSB +: 4] == `LSF_NIB_CLR)
      && (tx_push_word.data[31:8] == tx_in.data[31:8]);
  endproperty
  a_nib_clear: assert property (p_nib_clear) // see R05
    else $error("marker nibble not cleared");

  property p_hdr_first;
    @(posedge clock) disable iff (reset)
    (rx_st_r == lsf_pkg::LSF_RX_IDLE) && sid_valid
      |=> rx_push && rx_push_word.hdr
      && (rx_push_word.data[`LSF_TCODE_LSB +: 4] == `LSF_TCODE_SID);
  endproperty
  a_hdr_first: assert property (p_hdr_first) // see R09
    else $error("self-ID header missing");

  property p_body_pass;
    @(posedge clock) disable iff (reset)
    sid_fire |-> rx_push && !rx_push_word.hdr && !rx_push_word.stat
      && (rx_push_word.data == sid_data);
  endproperty
  a_body_pass: assert property (p_body_pass) // see R10
    else $error("self-ID word not stored");

  property p_stat_end;
    @(posedge clock) disable iff (reset)
    sid_fire && sid_last |=> (rx_st_r == lsf_pkg::LSF_RX_STAT) && !sid_ready;
  endproperty
  a_stat_end: assert property (p_stat_end) // see R11
    else $error("status quadlet not issued");

  property p_pri;
    @(posedge clock) disable iff (reset)
    (rx_st_r == lsf_pkg::LSF_RX_IDLE) && sid_valid
      |=> (rx_push_word.data[`LSF_PRI_LSB +: 4] == $past(rx_priority));
  endproperty
  a_pri: assert property (p_pri) // see R12
    else $error("header priority wrong");

  property p_spd;
    @(posedge clock) disable iff (reset)
    sid_fire && sid_last
      |=> rx_push_word.stat && (rx_push_word.data[`LSF_SPD_LSB +: 2] == $past(rx_speed));
  endproperty
  a_spd: assert property (p_spd) // see R13
    else $error("status speed wrong");

  property p_ack;
    @(posedge clock) disable iff (reset)
    sid_fire && sid_last
      |=> (rx_push_word.data[`LSF_ACK_LSB +: 4] == $past(returned_ack_code));
  endproperty
  a_ack: assert property (p_ack) // see R14
    else $error("status ack wrong");
endmodule : lsf_framer

/* test/lsf_sink.sv */
// Consumer model for one valid/ready stream of the framer
`timescale 1ns/1ps

module lsf_sink #(
  parameter int W = 34
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [1:0]   stall,
  input  wire logic         valid,
  output logic              ready,
  input  wire logic [W-1:0] data
);
  logic [W-1:0] q[$];
  logic [1:0]   ph_r;

  // Mode 0 takes every word, 1 one cycle in four, 2 none; ready moves only after an edge
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ready <= 1'b0;
      ph_r  <= 2'h0;
    end else begin
      if (valid && ready) q.push_back(data);
      ph_r  <= ph_r + 2'h1;
      ready <= (stall == 2'h0) || (stall == 2'h1 && ph_r == 2'h3);
    end
  end
endmodule : lsf_sink

/* test/lsf_framer_tb.sv */
// Self-checking bench for the link-on and self-ID framer
`timescale 1ns/1ps

module lsf_framer_tb;
  logic                   clock = 1'b0;
  logic                   reset = 1'b1;
  logic                   tx_valid = 1'b0;
  logic                   tx_ready;
  lsf_pkg::lsf_tx_in_t    tx_in = '0;
  logic                   phy_valid;
  logic                   phy_ready;
  lsf_pkg::lsf_phy_word_t phy_word;
  logic                   sid_valid = 1'b0;
  logic                   sid_ready;
  logic [31:0]            sid_data = 32'h0;
  logic                   sid_last = 1'b0;
  logic [3:0]             rx_priority = 4'h0;
  logic [1:0]             rx_speed = 2'h0;
  logic [3:0]             returned_ack_code = 4'h0;
  logic                   rxf_valid;
  logic                   rxf_ready;
  lsf_pkg::lsf_rx_word_t  rxf_word;
  logic [1:0]             phy_stall = 2'h0;
  logic [1:0]             rxf_stall = 2'h0;
  int                     n_errors = 0;
  int                     total_checks = 0;

  lsf_framer i_dut (.clock(clock), .reset(reset), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_in(tx_in), .phy_valid(phy_valid), .phy_ready(phy_ready), .phy_word(phy_word),
    .sid_valid(sid_valid), .sid_ready(sid_ready), .sid_data(sid_data), .sid_last(sid_last),
    .rx_priority(rx_priority), .rx_speed(rx_speed), .returned_ack_code(returned_ack_code),
    .rxf_valid(rxf_valid), .rxf_ready(rxf_ready), .rxf_word(rxf_word));
  lsf_sink i_phy (.clock(clock), .reset(reset), .stall(phy_stall), .valid(phy_valid),
    .ready(phy_ready), .data(phy_word));
  lsf_sink i_rxf (.clock(clock), .reset(reset), .stall(rxf_stall), .valid(rxf_valid),
    .ready(rxf_ready), .data(rxf_word));

  // 20 MHz clock
  always #25 clock = ~clock;

  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [33:0] exp, input logic [33:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  // Waits for ready before the edge, so a refused word is held, never dropped
  task automatic wait_rdy(input bit rx);
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge clock);
      if (rx ? sid_ready === 1'b1 : tx_ready === 1'b1) break;
    end
    if (i == 200) begin
      n_errors++;
      close_out();
    end
    @(posedge clock);
  endtask : wait_rdy

  // Valid stays high between words of one burst; dropped only after the final one
  task automatic push_tx(input logic [7:0] loc, input logic [31:0] d, input bit fin);
    tx_valid <= 1'b1;
    tx_in    <= {loc, d};
    wait_rdy(1'b0);
    if (fin) tx_valid <= 1'b0;
  endtask : push_tx

  task automatic wait_q(input bit rx, input int n);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clock);
      if ((rx ? i_rxf.q.size() : i_phy.q.size()) >= n) break;
    end
    if (i == 400) begin
      n_errors++;
      close_out();
    end
    repeat (4) @(posedge clock);
    chk(34'(n), 34'(rx ? i_rxf.q.size() : i_phy.q.size()));
  endtask : wait_q

  // Link-on request, idle link and stalling link
  task automatic t_link_on(input logic [1:0] st);
    logic [31:0] lead;
    logic [31:0] tail;
    lead = {2'b01, 6'h15, 8'h00, 16'h00e0};
    tail = {~lead[31:16], 16'hffff};
    phy_stall <= st;
    i_phy.q.delete();
    push_tx(8'h80, lead, 1'b0);
    push_tx(8'h8c, tail, 1'b1);
    wait_q(1'b0, 2);
    chk({2'b10, lead[31:8], 4'h0, lead[3:0]}, i_phy.q[0]);
    chk({2'b11, tail}, i_phy.q[1]);
  endtask : t_link_on

  // Not link-on: wrong marker, or marker outside the leading location
  task automatic t_plain(input logic [7:0] loc, input logic [31:0] lead);
    phy_stall <= 2'h0;
    i_phy.q.delete();
    push_tx(loc, lead, 1'b0);
    push_tx(8'h8c, 32'ha5a5_0f0f, 1'b1);
    wait_q(1'b0, 2);
    chk({2'b00, lead}, i_phy.q[0]);
    chk({2'b01, 32'ha5a5_0f0f}, i_phy.q[1]);
  endtask : t_plain

  // Stalled link: two words fill the buffer, then it refuses until drained
  task automatic t_fill();
    phy_stall <= 2'h2;
    i_phy.q.delete();
    push_tx(8'h84, 32'h1111_2222, 1'b0);
    push_tx(8'h8c, 32'h3333_4444, 1'b1);
    @(negedge clock);
    chk(34'h0, {33'h0, tx_ready});
    @(posedge clock);
    phy_stall <= 2'h0;
    wait_q(1'b0, 2);
    chk({2'b00, 32'h1111_2222}, i_phy.q[0]);
    chk({2'b01, 32'h3333_4444}, i_phy.q[1]);
    @(negedge clock);
    chk(34'h0, {33'h0, phy_valid});
    // Hand back on a rising edge so the next scenario drives there
    @(posedge clock);
  endtask : t_fill

  // Self-ID record: header, body in order, one status word
  task automatic t_selfid(input logic [1:0] spd, input logic [3:0] pri, input int n);
    rxf_stall   <= spd[0] ? 2'h1 : 2'h0;
    rx_priority <= pri;
    i_rxf.q.delete();
    for (int k = 0; k < n; k++) begin
      sid_valid         <= 1'b1;
      sid_data          <= {8'h80 + 8'(k), 8'(pri), 16'hc35a};
      sid_last          <= (k == n - 1);
      rx_speed          <= spd;
      returned_ack_code <= ~pri;
      wait_rdy(1'b1);
    end
    sid_valid <= 1'b0;
    wait_q(1'b1, n + 2);
    chk({2'b10, 24'h0, 4'he, pri}, i_rxf.q[0]);
    for (int k = 0; k < n; k++)
      chk({2'b00, 8'h80 + 8'(k), 8'(pri), 16'hc35a}, i_rxf.q[k + 1]);
    chk({2'b01, 14'h0, spd, 12'h0, ~pri}, i_rxf.q[n + 1]);
  endtask : t_selfid

  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_link_on(2'h0);
    t_link_on(2'h1);
    t_plain(8'h80, 32'h4321_00e1);
    t_plain(8'h84, 32'h4321_00e0);
    t_fill();
    t_selfid(2'h0, 4'h3, 1);
    t_selfid(2'h1, 4'h9, 3);
    t_selfid(2'h2, 4'hf, 4);
    close_out();
  end
endmodule : lsf_framer_tb
